/* File: irq_prio_two.sv */
// Notes on behaviour
// - bit 7 sets clock-valid interrupt priority
// - bit 6 reserved, reads zero, write zero
// - bit 5 sets external interrupt 7 priority
// - bit 4 sets external interrupt 6 priority
// - bit 3 sets external interrupt 5 priority
// - bit 2 sets external interrupt 4 priority
// - bit 1 sets conversion-done interrupt priority
// - bit 0 sets timer 3 priority
`timescale 1ns/1ps
`default_nettype none

module irq_prio_two (
  input  wire logic                          clock,            // system clock
  input  wire logic                          rst,              // sync reset, high
  input  wire logic [7:0]                    sfr_addr,         // sfr address
  input  wire logic                          sfr_wr,           // write strobe
  input  wire logic [7:0]                    sfr_wdata,        // write data
  output logic      [7:0]                    sfr_rdata,        // registered read data
  input  wire logic [6:0]                    irq_pending,      // requests, index = SRC_*
  input  wire logic                          in_service_low,   // core runs a low isr
  input  wire logic                          in_service_high,  // core runs a high isr
  output irq_prio_two_pkg::prio_levels_s     prio_levels,      // per-source level
  output irq_prio_two_pkg::grant_s           grant             // arbiter choice
);

  // priority register and its next value
  logic [7:0]                    reg_q;
  logic [7:0]                    reg_d;
  // registered read port and its next value
  logic [7:0]                    rdata_q;
  logic [7:0]                    rdata_d;
  // arbiter result, registered toward the core
  irq_prio_two_pkg::grant_s      grant_q;
  irq_prio_two_pkg::grant_s      grant_d;
  // arbiter view of the register, indexed like irq_pending
  logic [6:0]                    lvl;      // levels by source index, 1 = high
  logic [6:0]                    hi_req;   // pending requests at the high level
  logic [6:0]                    lo_req;   // pending requests at the low level

  // register update; reserved bit can never be stored, so a careless
  // write of ones cannot make bit 6 read back as one
  always_comb begin
    reg_d = reg_q; // hold between writes
    if (sfr_wr && sfr_addr == irq_prio_two_pkg::PRIO_TWO_ADDR) begin
      // whole byte taken in one edge; other addresses leave it alone
      reg_d = sfr_wdata & irq_prio_two_pkg::PRIO_TWO_WMASK;
    end
  end

  // read data follows the address one cycle later, any address reads zero elsewhere;
  // reg_d rather than reg_q is shown, so a read in the write cycle sees the new byte
  always_comb begin
    rdata_d = 8'h00; // unmapped addresses read zero
    if (sfr_addr == irq_prio_two_pkg::PRIO_TWO_ADDR) begin
      rdata_d = reg_d;
      // forced again here so the read port stays clean even if the mask changes
      rdata_d[irq_prio_two_pkg::BIT_RESERVED] = 1'b0;
    end
  end

  // map register bits to sources in arbiter order; the register lists sources
  // from bit 7 down while the arbiter counts from index 0 up, so the table
  // below is the only place where the two orders meet
  // a set lvl bit means that source sits at the high level
  always_comb begin
    lvl[irq_prio_two_pkg::SRC_CLOCK_VALID] = reg_q[irq_prio_two_pkg::BIT_CLOCK_VALID];
    lvl[irq_prio_two_pkg::SRC_EXT_IRQ7]    = reg_q[irq_prio_two_pkg::BIT_EXT_IRQ7];
    lvl[irq_prio_two_pkg::SRC_EXT_IRQ6]    = reg_q[irq_prio_two_pkg::BIT_EXT_IRQ6];
    lvl[irq_prio_two_pkg::SRC_EXT_IRQ5]    = reg_q[irq_prio_two_pkg::BIT_EXT_IRQ5];
    lvl[irq_prio_two_pkg::SRC_EXT_IRQ4]    = reg_q[irq_prio_two_pkg::BIT_EXT_IRQ4];
    lvl[irq_prio_two_pkg::SRC_CONV_DONE]   = reg_q[irq_prio_two_pkg::BIT_CONV_DONE];
    lvl[irq_prio_two_pkg::SRC_TIMER_THREE] = reg_q[irq_prio_two_pkg::BIT_TIMER_THREE];
    hi_req = irq_pending & lvl;
    lo_req = irq_pending & ~lvl;
  end

  // arbitration: any high request beats all low ones; a high request may
  // interrupt a low isr, nothing interrupts a high isr, a low request waits
  // until no isr runs. fixed index order breaks ties inside one level.
  // the core's own nesting state comes in on in_service_low/high; this block
  // only decides whom to offer, the core still decides when to take the vector
  always_comb begin
    grant_d = '0; // nothing offered unless a branch below finds a request
    // a running high isr blocks every request, whatever its level
    if (!in_service_high) begin
      // any high request wins over every low one
      if (hi_req != 7'h00) begin
        grant_d.valid = 1'b1;
        grant_d.high  = 1'b1;
        for (int i = irq_prio_two_pkg::NUM_SRC - 1; i >= 0; i--) begin
          if (hi_req[i]) begin
            grant_d.src = 3'(i);
          end
        end
        // no high request: low ones wait until no isr runs at all
      end else if (lo_req != 7'h00 && !in_service_low) begin
        grant_d.valid = 1'b1;
        for (int i = irq_prio_two_pkg::NUM_SRC - 1; i >= 0; i--) begin
          if (lo_req[i]) begin
            grant_d.src = 3'(i);
          end
        end
      end
    end
  end

  // priority register; a synchronous reset puts every source back at the low
  // level, so nothing is promoted before software has set the byte up
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_q <= irq_prio_two_pkg::PRIO_TWO_RESET; // all sources low
    end else begin
      reg_q <= reg_d;
    end
  end

  // read port register; cleared in reset so the bus never sees stale data
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // grant register; it costs one cycle of latency but keeps the core's
  // vector fetch off the arbiter's combinational path
  always_ff @(posedge clock) begin
    if (rst) begin
      grant_q <= '0; // no offer while in reset
    end else begin
      grant_q <= grant_d;
    end
  end

  // registered outputs toward the bus and the core
  assign sfr_rdata = rdata_q;
  assign grant     = grant_q;

  // per-source levels straight from the register flops; the struct lists
  // clock-valid first, so each field is wired by name and never through a
  // cast of the index-ordered lvl vector, whose bit order is the reverse
  always_comb begin
    prio_levels.clock_valid_priority     = reg_q[irq_prio_two_pkg::BIT_CLOCK_VALID];
    prio_levels.ext_irq7_priority        = reg_q[irq_prio_two_pkg::BIT_EXT_IRQ7];
    prio_levels.ext_irq6_priority        = reg_q[irq_prio_two_pkg::BIT_EXT_IRQ6];
    prio_levels.ext_irq5_priority        = reg_q[irq_prio_two_pkg::BIT_EXT_IRQ5];
    prio_levels.ext_irq4_priority        = reg_q[irq_prio_two_pkg::BIT_EXT_IRQ4];
    prio_levels.conversion_done_priority = reg_q[irq_prio_two_pkg::BIT_CONV_DONE];
    prio_levels.timer_three_priority     = reg_q[irq_prio_two_pkg::BIT_TIMER_THREE];
  end

  // checks; all run on the system clock, and all but the reset check sleep in reset
  // the map checks compare against raw register bits on purpose, so a slip
  // in the field positions or in the struct wiring shows up at once
  // the arbiter checks look one cycle back, because the grant is registered
  a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    !reg_q[irq_prio_two_pkg::BIT_RESERVED] && !sfr_rdata[irq_prio_two_pkg::BIT_RESERVED])
    else $error("reserved bit not zero");
  a_write_takes: assert property (@(posedge clock) disable iff (rst)
    sfr_wr && sfr_addr == irq_prio_two_pkg::PRIO_TWO_ADDR
    |=> reg_q == ($past(sfr_wdata) & irq_prio_two_pkg::PRIO_TWO_WMASK))
    else $error("write not stored");
  a_clock_valid_map: assert property (@(posedge clock) disable iff (rst)
    prio_levels.clock_valid_priority == reg_q[7]) else $error("bit 7 map");
  a_irq7_map: assert property (@(posedge clock) disable iff (rst)
    prio_levels.ext_irq7_priority == reg_q[5]) else $error("bit 5 map");
  a_irq6_map: assert property (@(posedge clock) disable iff (rst)
    prio_levels.ext_irq6_priority == reg_q[4]) else $error("bit 4 map");
  a_irq5_map: assert property (@(posedge clock) disable iff (rst)
    prio_levels.ext_irq5_priority == reg_q[3]) else $error("bit 3 map");
  a_irq4_map: assert property (@(posedge clock) disable iff (rst)
    prio_levels.ext_irq4_priority == reg_q[2]) else $error("bit 2 map");
  a_conv_map: assert property (@(posedge clock) disable iff (rst)
    prio_levels.conversion_done_priority == reg_q[1]) else $error("bit 1 map");
  a_timer_map: assert property (@(posedge clock) disable iff (rst)
    prio_levels.timer_three_priority == reg_q[0]) else $error("bit 0 map");
  a_high_first: assert property (@(posedge clock) disable iff (rst)
    (irq_pending & lvl) != 7'h00 && !in_service_high
    |=> grant.valid && grant.high
        && ((($past(lvl) >> grant.src) & 7'h01) != 7'h00)) else $error("high not first");
  a_no_low_preempt: assert property (@(posedge clock) disable iff (rst)
    in_service_low |=> !(grant.valid && !grant.high)) else $error("low preempted low");

  // reset and read-back checks
  a_reset_value: assert property (@(posedge clock)
    rst |=> reg_q == irq_prio_two_pkg::PRIO_TWO_RESET && sfr_rdata == 8'h00)
    else $error("reset value not restored");
  a_read_image: assert property (@(posedge clock) disable iff (rst)
    sfr_addr == irq_prio_two_pkg::PRIO_TWO_ADDR |=> sfr_rdata == reg_q)
    else $error("read image differs");
  // arbiter checks
  a_high_isr_blocks: assert property (@(posedge clock) disable iff (rst)
    in_service_high |=> !grant.valid) else $error("grant during high isr");
  a_low_waits: assert property (@(posedge clock) disable iff (rst)
    in_service_low && (irq_pending & lvl) == 7'h00 |=> !grant.valid)
    else $error("low request granted during low isr");
  a_low_granted: assert property (@(posedge clock) disable iff (rst)
    (irq_pending & ~lvl) != 7'h00 && (irq_pending & lvl) == 7'h00
    && !in_service_low && !in_service_high
    |=> grant.valid && !grant.high) else $error("low request not granted");
  a_grant_pending: assert property (@(posedge clock) disable iff (rst)
    grant.valid |-> ((($past(irq_pending) >> grant.src) & 7'h01) != 7'h00))
    else $error("grant for a source not pending");
  a_low_level_alone: assert property (@(posedge clock) disable iff (rst)
    grant.valid && !grant.high |-> $past(irq_pending & lvl) == 7'h00)
    else $error("low grant beside a high request");

  // scenarios worth seeing at least once: mixed levels, preemption, a full
  // write, a plain low grant and requests held off by a high isr
  c_high_over_low: cover property (@(posedge clock) disable iff (rst)
    ((irq_pending & lvl) != 7'h00) && ((irq_pending & ~lvl) != 7'h00));
  c_preempt: cover property (@(posedge clock) disable iff (rst)
    in_service_low ##1 grant.valid && grant.high);
  c_write_all: cover property (@(posedge clock) disable iff (rst) reg_q == 8'hBF);
  c_low_grant: cover property (@(posedge clock) disable iff (rst)
    grant.valid && !grant.high);
  c_high_isr_hold: cover property (@(posedge clock) disable iff (rst)
    in_service_high && irq_pending != 7'h00);

endmodule : irq_prio_two

`default_nettype wire

/* File: irq_prio_two_pkg.sv */
package irq_prio_two_pkg;

  // special-function address of the priority register
  localparam logic [7:0] PRIO_TWO_ADDR  = 8'hF7;
  // reset value: every source at the low level
  localparam logic [7:0] PRIO_TWO_RESET = 8'h00;
  // writable bits; bit 6 is held at zero
  localparam logic [7:0] PRIO_TWO_WMASK = 8'hBF;

  // field positions
  localparam int BIT_CLOCK_VALID = 7;
  localparam int BIT_RESERVED    = 6;
  localparam int BIT_EXT_IRQ7    = 5;
  localparam int BIT_EXT_IRQ6    = 4;
  localparam int BIT_EXT_IRQ5    = 3;
  localparam int BIT_EXT_IRQ4    = 2;
  localparam int BIT_CONV_DONE   = 1;
  localparam int BIT_TIMER_THREE = 0;

  // number of sources; the three-bit width of a source index is set in grant_s
  localparam int NUM_SRC = 7;

  // source index order used by the arbiter (lowest index wins a tie)
  localparam logic [2:0] SRC_CLOCK_VALID = 3'h0;
  localparam logic [2:0] SRC_EXT_IRQ7    = 3'h1;
  localparam logic [2:0] SRC_EXT_IRQ6    = 3'h2;
  localparam logic [2:0] SRC_EXT_IRQ5    = 3'h3;
  localparam logic [2:0] SRC_EXT_IRQ4    = 3'h4;
  localparam logic [2:0] SRC_CONV_DONE   = 3'h5;
  localparam logic [2:0] SRC_TIMER_THREE = 3'h6;

  // per-source priority levels as one bundle
  typedef struct packed {
    logic clock_valid_priority;
    logic ext_irq7_priority;
    logic ext_irq6_priority;
    logic ext_irq5_priority;
    logic ext_irq4_priority;
    logic conversion_done_priority;
    logic timer_three_priority;
  } prio_levels_s;

  // grant presented to the core
  typedef struct packed {
    logic       valid;
    logic       high;
    logic [2:0] src;
  } grant_s;

endpackage : irq_prio_two_pkg

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                           clock;        // system clock
  logic                           rst;          // sync reset, high
  logic [7:0]                     sfr_addr;     // sfr address
  logic                           sfr_wr;       // write strobe
  logic [7:0]                     sfr_wdata;    // write data
  logic [7:0]                     sfr_rdata;    // read data
  logic [6:0]                     irq_pending;  // pending requests
  logic                           in_service_low;  // low isr running
  logic                           in_service_high; // high isr running
  irq_prio_two_pkg::prio_levels_s prio_levels;  // per-source level
  irq_prio_two_pkg::grant_s       grant;        // arbiter choice
  int                             bad_count;    // mismatches
  int                             total_checks; // comparisons made
  logic [7:0]                     exp;          // expected register image

  irq_prio_two uut (.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq_pending(irq_pending),
    .in_service_low(in_service_low), .in_service_high(in_service_high),
    .prio_levels(prio_levels), .grant(grant));

  // free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // one compare; case inequality so an unknown never matches
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, want, seen);
    end
  endtask : check

  // single-cycle write strobe; strobe dropped at the next edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    sfr_addr  <= addr;
    sfr_wdata <= data;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr    <= 1'b0;
  endtask : wr

  // read data is registered, so it is looked at one edge after the address
  task automatic rd(input logic [7:0] addr, input logic [7:0] want);
    @(posedge clock);
    sfr_addr <= addr;
    @(posedge clock);
    #1;
    check("sfr_rdata", sfr_rdata, want);
  endtask : rd

  // grant is registered: inputs launched at one edge, result seen after the next
  task automatic arb(input logic [6:0] pend, input logic lo, input logic hi,
                     input logic [4:0] want);
    @(posedge clock);
    irq_pending     <= pend;
    in_service_low  <= lo;
    in_service_high <= hi;
    @(posedge clock);
    #1;
    check("grant", {3'h0, grant}, {3'h0, want});
  endtask : arb

  // single exit point for the run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    rst = 1'b1; sfr_addr = 8'h00; sfr_wr = 1'b0; sfr_wdata = 8'h00;
    irq_pending = 7'h00; in_service_low = 1'b0; in_service_high = 1'b0;
    bad_count = 0; total_checks = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // reset image, and an unmapped address reads zero
    rd(irq_prio_two_pkg::PRIO_TWO_ADDR, 8'h00);
    rd(8'hF6, 8'h00);
    // all ones written: the reserved bit must stay clear
    wr(irq_prio_two_pkg::PRIO_TWO_ADDR, 8'hFF);
    rd(irq_prio_two_pkg::PRIO_TWO_ADDR, 8'hBF);
    // a write to a neighbouring address must not touch the register
    wr(8'hF6, 8'h00);
    rd(irq_prio_two_pkg::PRIO_TWO_ADDR, 8'hBF);
    // walk a one through every bit and see which level follows it
    for (int i = 0; i < 8; i++) begin
      exp = (8'h01 << i) & 8'hBF;
      wr(irq_prio_two_pkg::PRIO_TWO_ADDR, 8'h01 << i);
      rd(irq_prio_two_pkg::PRIO_TWO_ADDR, exp);
      check("prio_levels", {1'b0, prio_levels}, {1'b0, exp[7], exp[5:0]});
    end
    // timer three high, clock-valid low: high level wins despite higher index
    wr(irq_prio_two_pkg::PRIO_TWO_ADDR, 8'h01);
    arb(7'h41, 1'b0, 1'b0, 5'h1E);
    arb(7'h01, 1'b0, 1'b0, 5'h10);
    arb(7'h01, 1'b1, 1'b0, 5'h00);
    arb(7'h41, 1'b1, 1'b0, 5'h1E);
    arb(7'h41, 1'b0, 1'b1, 5'h00);
    // all low: tie goes to the lower index
    wr(irq_prio_two_pkg::PRIO_TWO_ADDR, 8'h00);
    arb(7'h48, 1'b0, 1'b0, 5'h13);
    // clock-valid raised to high beats external interrupt 5
    wr(irq_prio_two_pkg::PRIO_TWO_ADDR, 8'h80);
    arb(7'h09, 1'b0, 1'b0, 5'h18);
    // mid-run reset: register, read port, levels and grant return to idle
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    #1;
    check("grant", {3'h0, grant}, 8'h00);
    check("sfr_rdata", sfr_rdata, 8'h00);
    check("prio_levels", {1'b0, prio_levels}, 8'h00);
    rd(irq_prio_two_pkg::PRIO_TWO_ADDR, irq_prio_two_pkg::PRIO_TWO_RESET);
    // clock-valid is low again after reset, so it is granted at the low level
    arb(7'h09, 1'b0, 1'b0, 5'h10);
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
